//--- hdl/sbp_defs.svh
// constants for the six-line port: offsets, fields, reset values, timing
`ifndef SBP_DEFS_SVH
`define SBP_DEFS_SVH

// ----------------------------------------------------------------
// register offsets in the i/o space
// ----------------------------------------------------------------
`define SBP_PIN_OFS     6'h16
`define SBP_DIR_OFS     6'h17
`define SBP_LATCH_OFS   6'h18
`define SBP_FLAG_OFS    6'h3a
`define SBP_MASK_OFS    6'h3b
`define SBP_BITOP_MAX   6'h1f

// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define SBP_EXTERNAL_IRQ_ZERO_ENABLE_BIT    3'h6
`define SBP_PCHG_BIT    3'h5
`define SBP_EXTERNAL_IRQ_ZERO_ENABLE_LINE   3'h1
`define SBP_IRQ_MASK    8'h60
`define SBP_LATCH_MASK  8'h1f
`define SBP_DIR_MASK_A  8'h1f
`define SBP_DIR_MASK_B  8'h3f

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SBP_REG_RST     8'h00
`define SBP_OEN_RST     6'h3f

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SBP_CLK_NS      20
`define SBP_RST_MIN_NS  50
`define SBP_RST_CYC     ((`SBP_RST_MIN_NS + `SBP_CLK_NS - 1) / `SBP_CLK_NS)

`endif

//--- hdl/sbp_pkg.sv
// types shared by the six-line port
package sbp_pkg;

  typedef enum logic [2:0] {
    SBP_CLK_CRYSTAL,
    SBP_CLK_LF_CRYSTAL,
    SBP_CLK_CERAMIC,
    SBP_CLK_EXT_RC,
    SBP_CLK_EXT_CLOCK,
    SBP_CLK_INT_RC
  } sbp_clk_sel_e;

  typedef struct packed {
    logic [5:0] addr;
    logic       wr;
    logic       rd;
    logic       bit_set;
    logic       bit_clr;
    logic [2:0] bit_idx;
    logic [7:0] wdata;
  } sbp_io_req_s;

endpackage

//--- hdl/sbp_port.sv
// six-line general-purpose port with pin sharing and pin-change events
`timescale 1ns/1ps
`include "sbp_defs.svh"

// Notes on behaviour
// - lines 0..4 are bidirectional, each with its own selectable pull-up
// - line 5 input only without eeprom, else open-drain output never high
// - any reset condition tri-states every line, clock or not
// - external reset enabled takes line 5 as reset input
// - crystal and ceramic types take lines 3,4; ext rc/clock take 3; internal rc none
// - reset pin low over 50 ns resets; driver must hold it long enough (the code resets on any low level, with no 50 ns filter)
// - flags clear by writing one; writing zero leaves them
// - bit set/clear rewrites the whole register from its read value
// - bit set/clear only acts on addresses 0x00 to 0x1f
// - in idle, pin-change and interrupt detection keep running
// - in power-down state is kept; interrupt or reset resumes
module sbp_port (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 reset_pin_n,
  input  wire logic                 ext_reset_en,
  input  wire logic                 has_eeprom,
  input  wire logic [2:0]           clk_sel,
  input  wire sbp_pkg::sbp_io_req_s io_req,
  output logic      [7:0]           io_rdata,
  input  wire logic [5:0]           pin_in,
  output logic      [5:0]           pin_out,
  output logic      [5:0]           pin_oe_n,
  output logic      [4:0]           pin_pullup_en,
  output logic                      ext_irq_zero_req,
  output logic                      pin_change_req,
  output logic                      wake_req
);
  import sbp_pkg::*;

  // ----------------------------------------------------------------
  // reset: the pin acts with no clock, so it joins the async reset
  // ----------------------------------------------------------------
  // no clock exists to time a 50 ns filter; any low level is taken
  wire arst = rst | (ext_reset_en & ~reset_pin_n);

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pin_s1, pin_s2, pin_prev;
  logic [3:0] cfg_s1, cfg_s2;
  logic [2:0] sync_fill;
  always_ff @(posedge sys_clk or posedge arst) begin
    if (arst) begin
      pin_s1   <= 6'h00;
      pin_s2   <= 6'h00;
      pin_prev <= 6'h00;
      cfg_s1   <= 4'h0;
      cfg_s2   <= 4'h0;
      sync_fill <= 3'h0;
    end else begin
      pin_s1   <= pin_in;
      pin_s2   <= pin_s1;
      pin_prev <= pin_s2;
      cfg_s1   <= {has_eeprom, clk_sel};
      cfg_s2   <= cfg_s1;
      sync_fill <= {sync_fill[1:0], 1'b1};
    end
  end

  wire          eeprom_v = cfg_s2[3];
  sbp_clk_sel_e osc_mode;
  assign osc_mode = sbp_clk_sel_e'(cfg_s2[2:0]);

  // ----------------------------------------------------------------
  // pin sharing
  // ----------------------------------------------------------------
  wire osc_three = (osc_mode != SBP_CLK_INT_RC);
  wire osc_four  = (osc_mode == SBP_CLK_CRYSTAL) |
                   (osc_mode == SBP_CLK_LF_CRYSTAL) |
                   (osc_mode == SBP_CLK_CERAMIC);
  wire [5:0] line_free = {~ext_reset_en, ~osc_four, ~osc_three, 3'h7};

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] dir_reg, latch_reg, mask_reg, flag_reg;

  wire [7:0] pin_rd   = {2'h0, pin_s2 & line_free};
  wire [7:0] dir_mask = eeprom_v ? `SBP_DIR_MASK_B : `SBP_DIR_MASK_A;

  wire sel_pin   = (io_req.addr == `SBP_PIN_OFS);
  wire sel_dir   = (io_req.addr == `SBP_DIR_OFS);
  wire sel_latch = (io_req.addr == `SBP_LATCH_OFS);
  wire sel_flag  = (io_req.addr == `SBP_FLAG_OFS);
  wire sel_mask  = (io_req.addr == `SBP_MASK_OFS);

  wire [7:0] rd_val = sel_pin   ? pin_rd    :
                      sel_dir   ? dir_reg   :
                      sel_latch ? latch_reg :
                      sel_flag  ? flag_reg  :
                      sel_mask  ? mask_reg  : 8'h00;

  // bit ops rewrite the whole byte from its read value
  wire       bitop_ok = (io_req.bit_set | io_req.bit_clr) &
                        (io_req.addr <= `SBP_BITOP_MAX);
  wire [7:0] bit_sel  = 8'h01 << io_req.bit_idx;
  wire [7:0] bit_val  = io_req.bit_set ? (rd_val | bit_sel) : (rd_val & ~bit_sel);
  wire       wr_eff   = io_req.wr | bitop_ok;
  wire [7:0] wd_eff   = bitop_ok ? bit_val : io_req.wdata;

  wire [7:0] next_dir   = (wr_eff & sel_dir)   ? (wd_eff & dir_mask) : (dir_reg & dir_mask);
  wire [7:0] next_latch = (wr_eff & sel_latch) ? (wd_eff & `SBP_LATCH_MASK) : latch_reg;
  wire [7:0] next_mask  = (wr_eff & sel_mask)  ? (wd_eff & `SBP_IRQ_MASK) : mask_reg;

  // ----------------------------------------------------------------
  // events: detection runs in every sleep mode while the clock runs
  // ----------------------------------------------------------------
  // the pin stages leave reset at zero; a line idling high would look like an edge,
  // so lines are compared only once three real samples are in
  wire       pins_live = sync_fill[2];
  wire       external_irq_zero_enable_fall = pins_live & pin_prev[`SBP_EXTERNAL_IRQ_ZERO_ENABLE_LINE] &
                         ~pin_s2[`SBP_EXTERNAL_IRQ_ZERO_ENABLE_LINE];
  wire       pchg_hit  = pins_live & (|((pin_prev ^ pin_s2) & line_free));
  wire [7:0] flag_set  = {1'b0, external_irq_zero_enable_fall, pchg_hit, 5'h00};
  wire [7:0] flag_clr  = (wr_eff & sel_flag) ? (wd_eff & `SBP_IRQ_MASK) : 8'h00;
  // a new event in the clearing cycle survives the clear
  wire [7:0] next_flag = flag_set | (flag_reg & ~flag_clr);

  wire [7:0] irq_live  = next_flag & next_mask;

  // state is only lost to reset, so power-down keeps every register
  always_ff @(posedge sys_clk or posedge arst) begin
    if (arst) begin
      dir_reg   <= `SBP_REG_RST;
      latch_reg <= `SBP_REG_RST;
      mask_reg  <= `SBP_REG_RST;
      flag_reg  <= `SBP_REG_RST;
      io_rdata  <= `SBP_REG_RST;
    end else begin
      dir_reg   <= next_dir;
      latch_reg <= next_latch;
      mask_reg  <= next_mask;
      flag_reg  <= next_flag;
      io_rdata  <= io_req.rd ? rd_val : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // pad control
  // ----------------------------------------------------------------
  wire [5:0] drive     = next_dir[5:0] & line_free &
                         {eeprom_v, 5'h1f};
  wire [5:0] next_out  = {1'b0, next_latch[4:0]};
  wire [4:0] next_pull = ~next_dir[4:0] & next_latch[4:0] & line_free[4:0];

  always_ff @(posedge sys_clk or posedge arst) begin
    if (arst) begin
      pin_out          <= 6'h00;
      pin_oe_n         <= `SBP_OEN_RST;
      pin_pullup_en    <= 5'h00;
      ext_irq_zero_req <= 1'b0;
      pin_change_req   <= 1'b0;
      wake_req         <= 1'b0;
    end else begin
      pin_out          <= next_out;
      pin_oe_n         <= ~drive;
      pin_pullup_en    <= next_pull;
      ext_irq_zero_req <= irq_live[`SBP_EXTERNAL_IRQ_ZERO_ENABLE_BIT];
      pin_change_req   <= irq_live[`SBP_PCHG_BIT];
      wake_req         <= |irq_live;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  int unsigned low_cnt;
  always_ff @(posedge sys_clk) begin
    low_cnt <= reset_pin_n ? 0 : low_cnt + 1;
  end

  a_reset_tristate: assert property (@(posedge sys_clk)
    (ext_reset_en && low_cnt >= `SBP_RST_CYC) |-> (pin_oe_n == 6'h3f && pin_pullup_en == 5'h00))
    else $error("lines not tri-stated under reset");

  a_line5_never_high: assert property (@(posedge sys_clk) disable iff (arst)
    pin_out[5] == 1'b0)
    else $error("line five driven high");

  a_line5_input_only: assert property (@(posedge sys_clk) disable iff (arst)
    (!eeprom_v && $past(!eeprom_v)) |-> pin_oe_n[5])
    else $error("line five driven without eeprom variant");

  a_reset_pin_takes: assert property (@(posedge sys_clk) disable iff (arst)
    ext_reset_en |-> (pin_oe_n[5] && !(io_rdata[5] && $past(io_req.rd && sel_pin))))
    else $error("line five used while it is the reset input");

  a_osc_lines_taken: assert property (@(posedge sys_clk) disable iff (arst)
    (osc_four && $past(osc_four)) |-> (pin_oe_n[4:3] == 2'h3 && pin_pullup_en[4:3] == 2'h0))
    else $error("oscillator lines used as port");

  a_flag_w1c: assert property (@(posedge sys_clk) disable iff (arst)
    (io_req.wr && sel_flag && !io_req.wdata[5] && flag_reg[5]) |=> flag_reg[5])
    else $error("writing zero cleared a flag");

  a_flag_clear_one: assert property (@(posedge sys_clk) disable iff (arst)
    (io_req.wr && sel_flag && io_req.wdata[6] && !external_irq_zero_enable_fall) |=> !flag_reg[6])
    else $error("writing one did not clear flag");

  a_bitop_range: assert property (@(posedge sys_clk) disable iff (arst)
    (io_req.bit_set && !io_req.wr && sel_mask) |=> $stable(mask_reg))
    else $error("bit op acted above its range");

  a_bitop_rewrite: assert property (@(posedge sys_clk) disable iff (arst)
    (io_req.bit_set && !io_req.wr && sel_latch && io_req.bit_idx == 3'h2) |=> latch_reg[2])
    else $error("bit set did not take");

  a_pullup_select: assert property (@(posedge sys_clk) disable iff (arst)
    (!dir_reg[0] && latch_reg[0]) |-> (pin_oe_n[0] && pin_pullup_en[0]))
    else $error("input line with pull-up is driven");

  a_change_detect: assert property (@(posedge sys_clk) disable iff (arst)
    (pchg_hit && mask_reg[5] && !(wr_eff && sel_mask)) |=> pin_change_req)
    else $error("pin change not detected");

  c_pin_change: cover property (@(posedge sys_clk) pin_change_req);
  c_external_irq_zero_enable_wake:  cover property (@(posedge sys_clk) ext_irq_zero_req && wake_req);
  c_bitop_port: cover property (@(posedge sys_clk) bitop_ok && sel_dir);
  c_drive_low5: cover property (@(posedge sys_clk) !pin_oe_n[5]);

endmodule

//--- verification/sbp_board.sv
// board model: pull-downs and test drivers on the six port lines
`timescale 1ns/1ps
module sbp_board (
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe_n,
  input  wire logic [4:0] pin_pullup_en,
  input  wire logic [5:0] ext_val,
  input  wire logic [5:0] ext_en,
  output logic      [5:0] pin_lvl
);
  wire [5:0] pull = {1'b0, pin_pullup_en};
  // weak board pull-downs: a released line never keeps its last value
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!pin_oe_n[i])
        pin_lvl[i] = (i == 5) ? 1'b0 : pin_out[i];
      else if (ext_en[i])
        pin_lvl[i] = ext_val[i];
      else
        pin_lvl[i] = pull[i];
    end
  end
endmodule

//--- verification/sbp_port_tb.sv
// self-checking bench for the six-line port
`timescale 1ns/1ps
`include "sbp_defs.svh"
module sbp_port_tb;
  import sbp_pkg::*;
  logic        sys_clk;
  logic        rst;
  logic        reset_pin_n;
  logic        ext_reset_en;
  logic        has_eeprom;
  logic [2:0]  clk_sel;
  sbp_io_req_s io_req;
  logic [7:0]  io_rdata;
  logic [5:0]  pin_lvl;
  logic [5:0]  pin_out;
  logic [5:0]  pin_oe_n;
  logic [5:0]  ext_val;
  logic [5:0]  ext_en;
  logic [4:0]  pin_pullup_en;
  logic        ext_irq_zero_req;
  logic        pin_change_req;
  logic        wake_req;
  int          bad_count;
  int          samples_checked;

  sbp_port u_sbp_port (.sys_clk(sys_clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .ext_reset_en(ext_reset_en), .has_eeprom(has_eeprom), .clk_sel(clk_sel),
    .io_req(io_req), .io_rdata(io_rdata), .pin_in(pin_lvl), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en),
    .ext_irq_zero_req(ext_irq_zero_req), .pin_change_req(pin_change_req),
    .wake_req(wake_req));
  sbp_board u_sbp_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pullup_en), .ext_val(ext_val), .ext_en(ext_en),
    .pin_lvl(pin_lvl));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // strobes last one cycle; read data is taken the cycle after
  task automatic io_op(input logic [5:0] a, input logic w, input logic r,
                       input logic s, input logic c, input logic [2:0] b,
                       input logic [7:0] d);
    @(posedge sys_clk);
    io_req <= '{addr: a, wr: w, rd: r, bit_set: s, bit_clr: c, bit_idx: b, wdata: d};
    @(posedge sys_clk);
    io_req <= '0;
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io_op(a, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, d);
  endtask
  task automatic rd(input string what, input logic [5:0] a, input logic [7:0] exp);
    io_op(a, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00);
    check(what, exp, io_rdata);
  endtask
  // two sync stages plus the output register
  task automatic settle;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #50000;
    bad_count++;
    complete_run;
  end
  initial begin
    rst = 1'b1;
    reset_pin_n = 1'b1;
    ext_reset_en = 1'b0;
    has_eeprom = 1'b1;
    clk_sel = SBP_CLK_INT_RC;
    io_req = '0;
    ext_val = 6'h04;
    ext_en = 6'h00;
    repeat (5) @(posedge sys_clk);
    #1;
    check("oe in reset", 8'h3f, {2'b0, pin_oe_n});
    @(posedge sys_clk);
    rst <= 1'b0;
    settle;
    wr(`SBP_DIR_OFS, 8'h3f);
    wr(`SBP_LATCH_OFS, 8'h15);
    rd("dir", `SBP_DIR_OFS, 8'h3f);
    check("oe", 8'h00, {2'b0, pin_oe_n});
    check("out", 8'h15, {2'b0, pin_out});
    settle;
    rd("pins", `SBP_PIN_OFS, 8'h15);
    $display("test drive done");
    wr(`SBP_DIR_OFS, 8'h00);
    wr(`SBP_LATCH_OFS, 8'h1f);
    rd("latch", `SBP_LATCH_OFS, 8'h1f);
    check("pullup", 8'h1f, {3'b0, pin_pullup_en});
    settle;
    rd("pins", `SBP_PIN_OFS, 8'h1f);
    io_op(`SBP_LATCH_OFS, 1'b0, 1'b0, 1'b0, 1'b1, 3'h2, 8'h00);
    rd("latch", `SBP_LATCH_OFS, 8'h1b);
    io_op(`SBP_LATCH_OFS, 1'b0, 1'b0, 1'b1, 1'b0, 3'h2, 8'h00);
    rd("latch", `SBP_LATCH_OFS, 8'h1f);
    io_op(`SBP_MASK_OFS, 1'b0, 1'b0, 1'b1, 1'b0, 3'h5, 8'h00);
    rd("mask", `SBP_MASK_OFS, 8'h00);
    $display("test pullup done");
    wr(`SBP_LATCH_OFS, 8'h00);
    settle;
    wr(`SBP_FLAG_OFS, 8'h60);
    rd("flag", `SBP_FLAG_OFS, 8'h00);
    wr(`SBP_MASK_OFS, 8'h20);
    @(posedge sys_clk);
    ext_en <= 6'h04;
    settle;
    rd("flag", `SBP_FLAG_OFS, 8'h20);
    check("wake", 8'h03, {6'b0, pin_change_req, wake_req});
    wr(`SBP_FLAG_OFS, 8'h00);
    rd("flag", `SBP_FLAG_OFS, 8'h20);
    wr(`SBP_FLAG_OFS, 8'h20);
    rd("flag", `SBP_FLAG_OFS, 8'h00);
    check("wake", 8'h00, {6'b0, pin_change_req, wake_req});
    wr(`SBP_MASK_OFS, 8'h40);
    @(posedge sys_clk);
    ext_val <= 6'h06;
    ext_en <= 6'h06;
    settle;
    @(posedge sys_clk);
    ext_val <= 6'h04;
    settle;
    rd("flag", `SBP_FLAG_OFS, 8'h60);
    check("external_irq_zero_enable", 8'h05, {5'b0, ext_irq_zero_req, pin_change_req, wake_req});
    wr(`SBP_FLAG_OFS, 8'h60);
    check("external_irq_zero_enable clr", 8'h00, {5'b0, ext_irq_zero_req, pin_change_req, wake_req});
    $display("test flags done");
    wr(`SBP_DIR_OFS, 8'h1f);
    for (int k = 0; k < 6; k++) begin
      @(posedge sys_clk);
      clk_sel <= 3'(k);
      settle;
      check("osc", k < 3 ? 8'h03 : (k < 5 ? 8'h01 : 8'h00), {6'b0, pin_oe_n[4:3]});
    end
    @(posedge sys_clk);
    has_eeprom <= 1'b0;
    settle;
    wr(`SBP_DIR_OFS, 8'h3f);
    rd("dir", `SBP_DIR_OFS, 8'h1f);
    $display("test sharing done");
    @(posedge sys_clk);
    rst <= 1'b1;
    ext_reset_en <= 1'b1;
    ext_val <= 6'h24;
    ext_en <= 6'h24;
    @(posedge sys_clk);
    rst <= 1'b0;
    settle;
    rd("flag after reset", `SBP_FLAG_OFS, 8'h00);
    wr(`SBP_DIR_OFS, 8'h01);
    rd("pins", `SBP_PIN_OFS, 8'h04);
    @(posedge sys_clk);
    reset_pin_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check("oe pin reset", 8'h3f, {2'b0, pin_oe_n});
    @(posedge sys_clk);
    reset_pin_n <= 1'b1;
    settle;
    rd("dir", `SBP_DIR_OFS, 8'h00);
    $display("test reset pin done");
    complete_run;
  end
endmodule
